// file: design/wake_cfg_pkg.sv
// Constants for the standby wake source configuration block
package wake_cfg_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CFG_B = 12'h004;
  localparam logic [11:0] ADDR_CFG_C = 12'h008;
  localparam logic [11:0] ADDR_CLEAR = 12'h00C;
  localparam logic [11:0] ADDR_STAT  = 12'h010;
  localparam logic [11:0] ADDR_MASK  = 12'h014;

  // ---------------------------------------------------------------
  // Field layout inside one 8-bit source slot
  // ---------------------------------------------------------------
  localparam int SLOT_W    = 8;
  localparam int MODE_LSB  = 4;
  localparam int SEEN_LSB  = 2;
  localparam int EN_BIT    = 0;
  localparam int UNDEF_BIT = 1;
  localparam int NSRC      = 4;

  // Slot position of each source: 4,5 in cfg B slots 0,1; 6,7 in cfg C
  localparam int SLOT_LO = 0;
  localparam int SLOT_HI = 1;
  localparam int SLOT_C7 = 2;

  // ---------------------------------------------------------------
  // Detection modes and seen-edge codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_LOW   = 3'h0;
  localparam logic [2:0] MODE_HIGH  = 3'h1;
  localparam logic [2:0] MODE_FALL  = 3'h2;
  localparam logic [2:0] MODE_RISE  = 3'h3;
  localparam logic [2:0] MODE_BOTH  = 3'h4;
  localparam logic [2:0] MODE_RESET = MODE_FALL;

  localparam logic [1:0] SEEN_NONE = 2'h0;
  localparam logic [1:0] SEEN_RISE = 2'h1;
  localparam logic [1:0] SEEN_FALL = 2'h2;

  // ---------------------------------------------------------------
  // Clear-request source codes
  // ---------------------------------------------------------------
  localparam logic [4:0] CLR_SRC4 = 5'h04;
  localparam logic [4:0] CLR_SRC5 = 5'h05;
  localparam logic [4:0] CLR_SRC6 = 5'h09;
  localparam logic [4:0] CLR_SRC7 = 5'h0A;

  // Value shown on bits that read as undefined
  localparam logic UNDEF_VAL = 1'b0;

endpackage : wake_cfg_pkg

// file: design/wake_detect.sv
// Detection of one wake source from its synchronised pin level
`timescale 1ns/10ps
`default_nettype none
module wake_detect
  import wake_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Configuration
  input  wire logic [2:0] mode,
  input  wire logic       enable,
  input  wire logic       clear,
  // Pin level already synchronised
  input  wire logic       pin_sync,
  // Results
  output logic [1:0]      seen_edge,
  output logic            pending,
  output logic            wake_event
);

  logic       pin_prev;
  logic       rise;
  logic       fall;
  logic       hit;
  logic [1:0] next_seen;

  assign rise = pin_sync & ~pin_prev;
  assign fall = ~pin_sync & pin_prev;

  always_comb begin
    unique case (mode)
      MODE_LOW:  hit = ~pin_sync;                             // RULE1
      MODE_HIGH: hit = pin_sync;                              // RULE1
      MODE_FALL: hit = fall;                                  // RULE1
      MODE_RISE: hit = rise;                                  // RULE1
      MODE_BOTH: hit = rise | fall;                           // RULE1
      default:   hit = 1'b0;
    endcase
  end

  // Edge record accumulates only in both-edge mode; set beats clear
  assign next_seen = (clear ? SEEN_NONE : seen_edge)          // RULE5
                   | ((mode == MODE_BOTH && enable)           // RULE4
                      ? {fall, rise} : SEEN_NONE);            // RULE3

  assign wake_event = hit & enable;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_prev  <= 1'b0;
      seen_edge <= SEEN_NONE;                                 // RULE16
      pending   <= 1'b0;
    end else begin
      pin_prev  <= pin_sync;
      seen_edge <= next_seen;
      pending   <= wake_event | (pending & ~clear);
    end
  end

endmodule : wake_detect
`default_nettype wire

// file: design/standby_wake_source_config.sv
// Standby wake source configuration with APB register access
//
// How it works
// RULE1 - Mode codes select level or edge detection
// RULE2 - Software never writes modes 101 to 111
// RULE3 - Seen-edge codes: none, rise, fall, both
// RULE4 - Seen-edge valid only in both-edge mode
// RULE5 - Clearing a request also clears seen-edge
// RULE6 - Software sets mode before enable, separately
// RULE7 - Source 5 fields at 14-12, 11-10, 8
// RULE8 - Source 4 fields at 6-4, 3-2, 0
// RULE9 - Source 4 enable gates its wake
// RULE10 - Source 7 fields at 22-20, 19-18, 16
// RULE11 - Source 7 enable gates its wake
// RULE12 - Source 6 fields at 14-12, 11-10, 8
// RULE13 - Source 6 seen-edge reads read-only codes
// RULE14 - Clear codes 04, 05, 09, 0A per source
// RULE15 - Reserved bits read zero or hold writes
// RULE16 - Reset: modes falling, seen zero, disabled
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module standby_wake_source_config
  import wake_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // External wake pins, asynchronous
  input  wire logic [3:0]  ext_irq,
  // Results
  output logic             standby_release,
  output logic [3:0]       wake_pending,
  output logic             irq
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [2:0]  mode       [NSRC];
  logic [NSRC-1:0] enable;
  logic [2:0]  spare_mode [NSRC];
  logic [NSRC-1:0] spare_en;
  logic [1:0]  seen       [NSRC];
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] evt;
  logic [NSRC-1:0] clr;
  logic [NSRC-1:0] stat;
  logic [NSRC-1:0] mask;
  logic [NSRC-1:0] sync1;
  logic [NSRC-1:0] sync2;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire rd       = access & ~pwrite;
  wire hit_b    = (paddr == ADDR_CFG_B);
  wire hit_c    = (paddr == ADDR_CFG_C);
  wire hit_clr  = (paddr == ADDR_CLEAR);
  wire hit_stat = (paddr == ADDR_STAT);
  wire hit_mask = (paddr == ADDR_MASK);
  wire mapped   = hit_b | hit_c | hit_clr | hit_stat | hit_mask;
  wire wr_b     = wr & hit_b;
  wire wr_c     = wr & hit_c;
  wire wr_clr   = wr & hit_clr;
  wire rd_stat  = rd & hit_stat;
  wire [4:0] clr_code = pwdata[4:0];

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Clear-request codes mapped to sources
  assign clr[0] = wr_clr & (clr_code == CLR_SRC4);            // RULE14
  assign clr[1] = wr_clr & (clr_code == CLR_SRC5);            // RULE14
  assign clr[2] = wr_clr & (clr_code == CLR_SRC6);            // RULE14
  assign clr[3] = wr_clr & (clr_code == CLR_SRC7);            // RULE14

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= ext_irq;
      sync2 <= sync1;
    end
  end

  // ---------------------------------------------------------------
  // Per-source configuration and detection
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      // Sources 4,5 live in cfg B slots 0,1; sources 6,7 in cfg C
      localparam int SLOT = (g < 2) ? g : g - 1;
      localparam int BASE = SLOT * SLOT_W;
      wire wsel = (g < 2) ? wr_b : wr_c;

      always_ff @(posedge clk) begin
        if (!rstn) begin
          mode[g]   <= MODE_RESET;                            // RULE16
          enable[g] <= 1'b0;                                  // RULE16
        end else if (wsel) begin
          mode[g]   <= pwdata[BASE+MODE_LSB +: 3];            // RULE7 RULE8 RULE10 RULE12
          enable[g] <= pwdata[BASE+EN_BIT];                   // RULE9 RULE11
        end
      end

      wake_detect wake_detect_inst (
        .clk       (clk),
        .rstn      (rstn),
        .mode      (mode[g]),
        .enable    (enable[g]),
        .clear     (clr[g]),
        .pin_sync  (sync2[g]),
        .seen_edge (seen[g]),
        .pending   (pend[g]),
        .wake_event(evt[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Unused slots: mode slots keep any value, enable slots are stored
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < NSRC; p++) begin : g_spare
      // Spares 0,1 are cfg B slots 2,3; spares 2,3 are cfg C slots 0,3
      localparam int SPOT  = (p < 2) ? p + 2 : (p == 2) ? SLOT_LO : 3;
      localparam int SBASE = SPOT * SLOT_W;
      wire spare_wsel = (p < 2) ? wr_b : wr_c;

      always_ff @(posedge clk) begin
        if (!rstn) begin
          spare_mode[p] <= MODE_RESET;
          spare_en[p]   <= 1'b0;
        end else if (spare_wsel) begin
          spare_mode[p] <= pwdata[SBASE+MODE_LSB +: 3];       // RULE15
          spare_en[p]   <= pwdata[SBASE+EN_BIT];              // RULE15
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Interrupt status and mask; a status read clears, set wins
  // ---------------------------------------------------------------
  // A read clears only the bits it returned, so an event landing
  // between the setup and access edges waits for the next read
  wire [NSRC-1:0] stat_taken = rd_stat ? prdata[NSRC-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stat <= '0;
      mask <= '0;
    end else begin
      stat <= (stat & ~stat_taken) | evt;
      if (wr & hit_mask) begin
        mask <= pwdata[NSRC-1:0];
      end
    end
  end

  assign irq             = |(stat & mask);
  assign standby_release = |evt;                              // RULE9 RULE11
  assign wake_pending    = pend;

  // ---------------------------------------------------------------
  // Read data; reserved bits read zero, undefined bits read fixed
  // ---------------------------------------------------------------
  function automatic logic [7:0] slot_val(
    input logic [2:0] m,
    input logic [1:0] s,
    input logic       e
  );
    slot_val = {1'b0, m, s, UNDEF_VAL, e};                    // RULE15
  endfunction : slot_val

  wire [31:0] rd_b = {slot_val(spare_mode[1], SEEN_NONE, spare_en[1]),
                      slot_val(spare_mode[0], SEEN_NONE, spare_en[0]),
                      slot_val(mode[1], seen[1], enable[1]),  // RULE7
                      slot_val(mode[0], seen[0], enable[0])}; // RULE8
  wire [31:0] rd_c = {slot_val(spare_mode[3], SEEN_NONE, spare_en[3]),
                      slot_val(mode[3], seen[3], enable[3]),  // RULE10
                      slot_val(mode[2], seen[2], enable[2]),  // RULE12 RULE13
                      slot_val(spare_mode[2], SEEN_NONE, spare_en[2])};
  wire [31:0] rd_mux = hit_b    ? rd_b :
                       hit_c    ? rd_c :
                       hit_stat ? {28'h000_0000, stat} :
                       hit_mask ? {28'h000_0000, mask} :
                       32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule : standby_wake_source_config
`default_nettype wire

// file: verif/wake_pins_model.sv
// Board-side driver of the four external wake pins
`timescale 1ns/10ps
`default_nettype none
module wake_pins_model (
  // Clock
  input  wire logic       clk,
  // Levels asked for by the bench
  input  wire logic [3:0] level_req,
  // Pins into the block
  output logic [3:0]      ext_irq
);
  always_ff @(posedge clk) ext_irq <= level_req;
endmodule : wake_pins_model
`default_nettype wire

// file: verif/wake_cfg_assertions.sv
// Port assertions for the wake source configuration block
`timescale 1ns/10ps
`default_nettype none
module wake_cfg_checker
  import wake_cfg_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Results
  input wire logic        standby_release,
  input wire logic [3:0]  wake_pending,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  logic acc;
  logic mapped;
  assign acc = psel & penable;
  assign mapped = paddr inside {ADDR_CFG_B, ADDR_CFG_C, ADDR_CLEAR,
                                ADDR_STAT, ADDR_MASK};
  // ----------
  // Assertions
  // ----------
  reset_pending_a: assert property (!rstn |=> wake_pending == 4'h0)
    else $error("pending set after reset");
  reset_irq_a: assert property (!rstn |=> !irq)
    else $error("irq high after reset");
  reset_release_a: assert property ($rose(rstn) |-> !standby_release [*2])
    else $error("release while all sources disabled");
  cfg_b_zero_a: assert property (disable iff (!rstn)
    acc && !pwrite && paddr == ADDR_CFG_B |-> (prdata & 32'h8C8C_8080) == 0)
    else $error("cfg B reserved bits not zero");
  cfg_c_zero_a: assert property (disable iff (!rstn)
    acc && !pwrite && paddr == ADDR_CFG_C |-> (prdata & 32'h8C80_808C) == 0)
    else $error("cfg C reserved bits not zero");
  bus_ready_a: assert property (disable iff (!rstn) acc |-> pready)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (disable iff (!rstn)
    acc && !mapped && !pwrite |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  release_pend_a: assert property (disable iff (!rstn)
    $rose(standby_release) |-> ##[1:2] wake_pending != 4'h0)
    else $error("release without pending");
  cover property (acc && pwrite && paddr == ADDR_CFG_C);
  cover property ($rose(irq));
  cover property ($rose(standby_release));
endmodule : wake_cfg_checker
bind standby_wake_source_config wake_cfg_checker wake_cfg_checker_inst (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .standby_release(standby_release),
  .wake_pending(wake_pending), .irq(irq));
`default_nettype wire

// file: verif/standby_wake_source_config_bench.sv
// Self-checking bench for the wake source configuration block
`timescale 1ns/10ps
`default_nettype none
module standby_wake_source_config_bench import wake_cfg_pkg::*;;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic        standby_release, irq, err, hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  wake_pending, ext_irq, level_req;
  logic [4:0]  code [4] = '{CLR_SRC4, CLR_SRC5, CLR_SRC6, CLR_SRC7};
  int          miscompares, n_tests;

  standby_wake_source_config standby_wake_source_config_inst (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .ext_irq(ext_irq),
    .standby_release(standby_release), .wake_pending(wake_pending),
    .irq(irq));
  wake_pins_model wake_pins_model_inst (
    .clk(clk), .level_req(level_req), .ext_irq(ext_irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // -----------
  // Shared tasks
  // -----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic watch(input logic exp);
    hit = 1'b0;
    repeat (8) begin
      @(posedge clk);
      if (standby_release === 1'b1) hit = 1'b1;
    end
    check(32'(hit), 32'(exp));
  endtask : watch

  // One source in one mode: enable, active input, gating, clear
  task automatic run_mode(input int s, input logic [2:0] m);
    logic [11:0] a;
    logic [31:0] v, e;
    logic        idle;
    int          sh;
    a = (s < 2) ? ADDR_CFG_B : ADDR_CFG_C;
    sh = (s == 0) ? 0 : (s == 3) ? 16 : 8;
    v = (32'h2020_2020 & ~(32'hFF << sh)) | (32'(m) << (sh + 4));
    e = v | (32'h1 << sh);
    idle = (m == MODE_LOW || m == MODE_FALL);
    apb(1'b1, a, v);
    level_req[s] <= idle;
    repeat (8) @(posedge clk);
    apb(1'b1, ADDR_CLEAR, {27'h0, code[s]});
    apb(1'b1, a, e);
    watch(1'b0);
    level_req[s] <= ~idle;
    watch(1'b1);
    check(32'(wake_pending[s]), 32'h1);
    level_req[s] <= idle;
    if (m >= MODE_FALL) begin
      watch(m == MODE_BOTH);
      apb(1'b0, a, 32'h0);
      check(rd, e | (m == MODE_BOTH ? 32'h3 << (sh + 2) : 0));
    end
    if (m == MODE_BOTH) begin
      apb(1'b1, ADDR_CLEAR, {27'h0, code[s]});
      apb(1'b0, a, 32'h0);
      check(rd, e);
      check(32'(wake_pending[s]), 32'h0);
    end
    apb(1'b1, a, v);
    level_req[s] <= ~idle;
    watch(1'b0);
  endtask : run_mode

  task automatic print_verdict;
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, level_req} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, ADDR_CFG_B, 32'h0);
    check(rd, 32'h2020_2020);
    apb(1'b0, ADDR_CFG_C, 32'h0);
    check(rd, 32'h2020_2020);
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, r ? ADDR_CFG_C : ADDR_CFG_B, 32'hBC9C_CCBC);
      apb(1'b0, r ? ADDR_CFG_C : ADDR_CFG_B, 32'h0);
      check(rd, 32'h3010_4030);
    end
    apb(1'b0, 12'h020, 32'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    for (int s = 0; s < 4; s++)
      for (int m = 0; m < 5; m++)
        run_mode(s, 3'(m));
    apb(1'b0, ADDR_STAT, 32'h0);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, ADDR_MASK, 32'h1);
    apb(1'b1, ADDR_CFG_B, 32'h2020_2020);
    apb(1'b1, ADDR_CFG_B, 32'h2020_2021);
    for (int k = 0; k < 2; k++) begin
      level_req[0] <= 1'b1;
      repeat (8) @(posedge clk);
      level_req[0] <= 1'b0;
      repeat (8) @(posedge clk);
      check(32'(irq), k ? 32'h0 : 32'h1);
      apb(1'b0, ADDR_STAT, 32'h0);
      check(rd, 32'h1);
      @(posedge clk);
      check(32'(irq), 32'h0);
      apb(1'b1, ADDR_MASK, 32'h0);
    end
    print_verdict();
  end
endmodule : standby_wake_source_config_bench
`default_nettype wire
